// *** hw/cgr_top.sv ***
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`include "cgr_consts.svh"
// Overview of operation
// - An internal reset runs after every power-up, whatever the reset pin does.
// - Reset pin low clears all dividers and drops PLL lock.
// - Relock time grows with how long the reset pin stayed low.
// - A high output-enable pin keeps its bank outputs in high impedance.
// - Configuration is written over a four-wire test port and kept nonvolatile.
// - A 32-bit user signature is held and writable by the user.
// - Once the lock bit is set, configuration readout is refused.
// - The lock bit clears only through the erase instruction, which also clears configuration but not the signature.
// - With external feedback, feedback rising edge aligns to reference edge.
// - User-code instruction 8'h17 loads the signature into a 32-bit shift register.
// - Lock-program instruction 8'h09 sets the lock bit.
module cgr_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reset_pin_n,
    input wire logic output_enable_group_x_n,
    input wire logic output_enable_group_y_n,
    input wire logic ext_fb_sel,
    input wire logic ref_in,
    input wire logic fb_in,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    output logic bank_x_oe,
    output logic bank_y_oe,
    output logic pll_locked,
    output logic phase_up,
    output logic phase_down,
    output logic [`CGR_DIV_LEN-1:0] div_count,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // Two-flop synchronisers for the pins, apart from ext_fb_sel, which is used directly.
    // Synchronisers reset to the idle level of their pins, so that no false
    // reset, enable or clock edge is seen just after power-up.
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
        end else begin
            s1_q <= {reset_pin_n, output_enable_group_x_n};
            s2_q <= s1_q;
        end
    end
    logic [5:0] sa_q;
    logic [5:0] sb_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sa_q <= 6'h20;
            sb_q <= 6'h20;
        end else begin
            sa_q <= {output_enable_group_y_n, ref_in, fb_in, tck, tms, tdi};
            sb_q <= sa_q;
        end
    end
    wire rst_pin_n_s = s2_q[1];
    wire oex_n_s = s2_q[0];
    wire oey_n_s = sb_q[5];
    wire ref_s = sb_q[4];
    wire fb_s = sb_q[3];
    wire tck_s = sb_q[2];
    wire tms_s = sb_q[1];
    wire tdi_s = sb_q[0];

    // Power-on reset counter; nrst models power being applied.
    logic [`CGR_CNT_W-1:0] por_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            por_q <= '0;
        end else if (por_q != `CGR_CNT_W'(`CGR_POR_CYCLES)) begin
            por_q <= por_q + 1'b1;
        end
    end
    wire por_busy = (por_q != `CGR_CNT_W'(`CGR_POR_CYCLES));
    wire core_rst = por_busy || !rst_pin_n_s;

    // Output dividers are cleared while reset stands.
    logic [`CGR_DIV_LEN-1:0] div_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
        end else if (core_rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign div_count = div_q;

    // The longer reset is held, the further the oscillator drifts down, so the
    // acquire time is the base plus the cycles spent in reset, saturating.
    cgr_pkg::cgr_pll_state_t pll_q;
    logic [`CGR_CNT_W-1:0] drift_q;
    logic [`CGR_CNT_W-1:0] acq_q;
    wire drift_max = &drift_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pll_q <= cgr_pkg::CGR_PLL_RESET;
            drift_q <= '0;
            acq_q <= '0;
        end else begin
            unique case (pll_q)
                cgr_pkg::CGR_PLL_RESET: begin
                    if (!core_rst) begin
                        pll_q <= cgr_pkg::CGR_PLL_ACQUIRE;
                        acq_q <= '0;
                    end else if (!drift_max) begin
                        drift_q <= drift_q + 1'b1;
                    end
                end
                cgr_pkg::CGR_PLL_ACQUIRE: begin
                    if (core_rst) begin
                        pll_q <= cgr_pkg::CGR_PLL_RESET;
                    end else if (acq_q >= drift_q + `CGR_CNT_W'(`CGR_LOCK_BASE)) begin
                        pll_q <= cgr_pkg::CGR_PLL_LOCKED;
                        drift_q <= '0;
                    end else begin
                        acq_q <= acq_q + 1'b1;
                    end
                end
                cgr_pkg::CGR_PLL_LOCKED: begin
                    if (core_rst) begin
                        pll_q <= cgr_pkg::CGR_PLL_RESET;
                    end
                end
            endcase
        end
    end
    assign pll_locked = (pll_q == cgr_pkg::CGR_PLL_LOCKED);

    // Phase detector: steer toward reference edge when external feedback is used.
    logic ref_d1_q;
    logic fb_d1_q;
    logic up_q;
    logic dn_q;
    wire ref_rise = ref_s && !ref_d1_q;
    wire fb_rise = fb_s && !fb_d1_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ref_d1_q <= 1'b0;
            fb_d1_q <= 1'b0;
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            ref_d1_q <= ref_s;
            fb_d1_q <= fb_s;
            up_q <= ext_fb_sel && !core_rst && ref_rise && !fb_rise;
            dn_q <= ext_fb_sel && !core_rst && fb_rise && !ref_rise;
        end
    end
    assign phase_up = up_q;
    assign phase_down = dn_q;

    assign bank_x_oe = !oex_n_s;
    assign bank_y_oe = !oey_n_s;

    // Test port: simplified shifter, TMS low shifts, TMS high updates.
    logic tck_d1_q;
    logic [`CGR_IR_LEN-1:0] ir_q;
    logic [`CGR_SIG_LEN-1:0] dr_q;
    logic ir_mode_q;
    logic [`CGR_SIG_LEN-1:0] sig_q;
    logic [`CGR_CFG_LEN-1:0] cfg_q;
    logic lock_q;
    logic tdo_q;
    wire tck_rise = tck_s && !tck_d1_q;
    wire tck_fall = !tck_s && tck_d1_q;
    wire ins_user = (ir_q == `CGR_INS_USERCODE);
    wire ins_cfg = (ir_q == `CGR_INS_CFGSHIFT);
    wire cfg_read_ok = !lock_q;
    wire bus_sel_sig = avs_write && (avs_address == `CGR_REG_SIG);
    wire tap_exec = tck_rise && tms_s && !ir_mode_q;
    wire ins_prog = tap_exec && (ir_q == `CGR_INS_PROGRAM);
    wire ins_sigw = tap_exec && (ir_q == `CGR_INS_SIGWRITE);
    wire ins_lock = tap_exec && (ir_q == `CGR_INS_LOCKPROG);
    wire ins_erase = tap_exec && (ir_q == `CGR_INS_ERASE);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tck_d1_q <= 1'b0;
            ir_q <= `CGR_INS_BYPASS;
            dr_q <= '0;
            ir_mode_q <= 1'b0;
            tdo_q <= 1'b0;
        end else begin
            tck_d1_q <= tck_s;
            if (tck_fall) begin
                tdo_q <= ir_mode_q ? ir_q[0] : dr_q[0];
            end
            if (tck_rise && tms_s) begin
                if (ir_mode_q) begin
                    ir_mode_q <= 1'b0;
                end else if (ir_q == `CGR_INS_BYPASS) begin
                    ir_mode_q <= 1'b1;
                end else begin
                    // Falling back to bypass lets the next frame reach the
                    // instruction register without a full test port reset.
                    ir_q <= `CGR_INS_BYPASS;
                    if (ins_user) begin
                        dr_q <= sig_q;
                    end else if (ins_cfg) begin
                        dr_q <= cfg_read_ok ? cfg_q : '0;
                    end
                end
            end else if (tck_rise) begin
                if (ir_mode_q) begin
                    ir_q <= {tdi_s, ir_q[`CGR_IR_LEN-1:1]};
                end else begin
                    dr_q <= {tdi_s, dr_q[`CGR_SIG_LEN-1:1]};
                end
            end
        end
    end
    // Nonvolatile cells: power-up (nrst) must not touch them, so they have no
    // reset; a fresh part holds unknown configuration and lock until erased, and an unknown signature until written.
    always_ff @(posedge ref_clk) begin
        if (bus_sel_sig) begin
            sig_q <= avs_writedata;
        end else if (ins_sigw) begin
            sig_q <= dr_q;
        end
        if (ins_prog) begin
            cfg_q <= dr_q;
        end else if (ins_erase) begin
            cfg_q <= `CGR_CFG_RESET;
        end
        if (ins_lock) begin
            lock_q <= 1'b1;
        end else if (ins_erase) begin
            lock_q <= 1'b0;
        end
    end
    assign tdo = tdo_q;
    assign tdo_oe = 1'b1;

    // Avalon slave, one wait state on reads and none on writes; reads of config honour the lock.
    logic [31:0] rd_q;
    wire [31:0] stat_w = {29'h0, lock_q, pll_locked, core_rst};
    wire [31:0] cfg_view = cfg_read_ok ? cfg_q : 32'h00000000;
    wire [31:0] rd_d = (avs_address == `CGR_REG_STAT) ? stat_w :
                       (avs_address == `CGR_REG_SIG) ? sig_q :
                       (avs_address == `CGR_REG_CFG) ? cfg_view :
                       (avs_address == `CGR_REG_CTRL) ? {24'h0, ir_q} : 32'h00000000;
    logic rd_pend_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_q <= 32'h00000000;
            rd_pend_q <= 1'b0;
        end else begin
            rd_pend_q <= avs_read && !rd_pend_q;
            if (avs_read && !rd_pend_q) begin
                rd_q <= rd_d;
            end
        end
    end
    assign avs_readdata = rd_q;
    assign avs_waitrequest = avs_read && !rd_pend_q;

    property p_div_clear;
        @(posedge ref_clk) disable iff (!nrst) core_rst |=> div_q == '0;
    endproperty
    a_div_clear: assert property (p_div_clear) else $error("divider not cleared");
    property p_lock_drop;
        @(posedge ref_clk) disable iff (!nrst) core_rst |=> !pll_locked;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock held in reset");
    property p_por;
        @(posedge ref_clk) disable iff (!nrst) por_busy |-> !pll_locked;
    endproperty
    a_por: assert property (p_por) else $error("lock during power-up");
    // The enables follow their pins two clocks late, through the synchronisers.
    property p_oe;
        @(posedge ref_clk) disable iff (!nrst)
            !por_busy |-> bank_x_oe == !$past(output_enable_group_x_n, 2) &&
            bank_y_oe == !$past(output_enable_group_y_n, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("bank enable wrong");
    property p_lock_read;
        @(posedge ref_clk) disable iff (!nrst) lock_q |-> cfg_view == 32'h0;
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("locked config readable");
    property p_lock_sticky;
        @(posedge ref_clk) disable iff (!nrst) $fell(lock_q) |-> $past(ir_q) == `CGR_INS_ERASE;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");
    property p_wait;
        @(posedge ref_clk) disable iff (!nrst) avs_read |-> ##[0:1] !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("read stalled");
    property p_phase;
        @(posedge ref_clk) disable iff (!nrst) !ext_fb_sel |=> !phase_up && !phase_down;
    endproperty
    a_phase: assert property (p_phase) else $error("phase steer");
endmodule

// *** hw/cgr_consts.svh ***
`ifndef CGR_CONSTS_SVH
`define CGR_CONSTS_SVH
`define CGR_IR_LEN 8
`define CGR_SIG_LEN 32
`define CGR_CFG_LEN 32
`define CGR_INS_USERCODE 8'h17
`define CGR_INS_LOCKPROG 8'h09
`define CGR_INS_ERASE 8'h03
`define CGR_INS_PROGRAM 8'h07
`define CGR_INS_SIGWRITE 8'h18
`define CGR_INS_CFGSHIFT 8'h02
`define CGR_INS_BYPASS 8'hFF
`define CGR_POR_CYCLES 16
`define CGR_LOCK_BASE 64
`define CGR_DIV_LEN 8
`define CGR_CNT_W 16
`define CGR_SIG_RESET 32'h00000000
`define CGR_CFG_RESET 32'h00000000
`define CGR_REG_CTRL 32'h00000000
`define CGR_REG_STAT 32'h00000004
`define CGR_REG_SIG 32'h00000008
`define CGR_REG_CFG 32'h0000000C
`endif

// *** hw/cgr_pkg.sv ***
package cgr_pkg;
    typedef enum logic [1:0] {
        CGR_PLL_RESET,
        CGR_PLL_ACQUIRE,
        CGR_PLL_LOCKED
    } cgr_pll_state_t;
endpackage

// *** test/cgr_host.sv ***
`timescale 1ns/10ps
// Programming host: its test clock runs only inside a frame and stands low between frames.
module cgr_host (
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b0;
        tdi = 1'b0;
    end
    task automatic bit_out(input logic m, input logic d);
        tms = m;
        tdi = d;
        #160 tck = 1'b1;
        #160 tck = 1'b0;
    endtask
    // One instruction and one 32-bit word, both least significant bit first.
    task automatic op(input logic [7:0] ins, input logic [31:0] dat);
        int i;
        bit_out(1'b1, 1'b0);
        for (i = 0; i < 8; i++) bit_out(1'b0, ins[i]);
        bit_out(1'b1, 1'b0);
        for (i = 0; i < 32; i++) bit_out(1'b0, dat[i]);
        bit_out(1'b1, 1'b0);
        tdi = ~tdi;
        // The pins are synchronised, so give the last command time to land.
        #320;
    endtask
endmodule

// *** test/clock_gen_reset_and_config_security_tb.sv ***
`timescale 1ns/10ps
`include "cgr_consts.svh"
module clock_gen_reset_and_config_security_tb;
    logic ref_clk, nrst, reset_pin_n, ext_fb_sel, ref_in, fb_in, tck, tms, tdi, wq;
    logic tdo, tdo_oe;
    logic output_enable_group_x_n, output_enable_group_y_n, avs_read, avs_write;
    logic bank_x_oe, bank_y_oe, pll_locked, phase_up, phase_down, avs_waitrequest;
    logic [7:0] div_count, ph;
    logic [31:0] avs_address, avs_writedata, avs_readdata, rd_s, v, q;
    integer seed = 41;
    int failures = 0, checks = 0, npulse = 0, na, nb;
    cgr_top u_dut (.ref_clk, .nrst, .reset_pin_n, .output_enable_group_x_n,
        .output_enable_group_y_n, .ext_fb_sel, .ref_in, .fb_in, .tck, .tms, .tdi,
        .tdo, .tdo_oe, .bank_x_oe, .bank_y_oe, .pll_locked, .phase_up,
        .phase_down, .div_count, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest);
    cgr_host u_host (.tck, .tms, .tdi);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Settled copies of the slave's answer, as they stand at the next rising edge.
    always @(negedge ref_clk) begin
        wq = avs_waitrequest;
        rd_s = avs_readdata;
    end
    always @(posedge ref_clk) begin
        ph <= ph + 8'h01;
        ref_in <= ph[3];
        fb_in <= ref_in;
        if (phase_up | phase_down) npulse <= npulse + 1;
    end
    task automatic results();
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        failures++;
        results();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wq !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        r = rd_s;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [31:0] a, e);
        bus(1'b0, a, 32'h00000000, q);
        chk(q, e);
    endtask
    task automatic tlock(output int n);
        n = 0;
        while (pll_locked !== 1'b1 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic por();
        @(posedge ref_clk);
        nrst <= 1'b0;
        cyc(3);
        nrst <= 1'b1;
        cyc(`CGR_POR_CYCLES);
        chk(pll_locked, 1'b0);
        tlock(na);
        chk(na > `CGR_LOCK_BASE - 8 && na < 3000, 1'b1);
    endtask
    task automatic pin(input int len, output int n);
        @(posedge ref_clk);
        reset_pin_n <= 1'b0;
        cyc(len);
        @(negedge ref_clk);
        chk(div_count, 8'h00);
        chk(pll_locked, 1'b0);
        @(posedge ref_clk);
        reset_pin_n <= 1'b1;
        tlock(n);
    endtask
    initial begin
        nrst = 1'b0;
        reset_pin_n = 1'b1;
        output_enable_group_x_n = 1'b1;
        output_enable_group_y_n = 1'b1;
        ext_fb_sel = 1'b0;
        ref_in = 1'b0;
        fb_in = 1'b0;
        ph = 8'h00;
        avs_address = 32'h00000000;
        avs_writedata = 32'h00000000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        por();
        u_host.op(`CGR_INS_ERASE, 32'h00000000);
        rdc(`CGR_REG_STAT, 32'h00000002);
        wr(32'h00000010, 32'hFFFFFFFF);
        rdc(32'h00000010, 32'h00000000);
        repeat (8) begin
            v = $random(seed);
            @(posedge ref_clk);
            output_enable_group_x_n <= v[0];
            output_enable_group_y_n <= v[1];
            cyc(5);
            chk({bank_x_oe, bank_y_oe}, {30'h0, ~v[0], ~v[1]});
        end
        repeat (4) begin
            v = $random(seed);
            wr(`CGR_REG_SIG, v);
            rdc(`CGR_REG_SIG, v);
        end
        pin(5, na);
        pin(100, nb);
        chk(nb >= na + 90 && na >= `CGR_LOCK_BASE, 1'b1);
        @(posedge ref_clk);
        ext_fb_sel <= 1'b1;
        nb = npulse;
        cyc(200);
        chk(npulse > nb, 1'b1);
        v = $random(seed);
        u_host.op(`CGR_INS_PROGRAM, v);
        pin(8, na);
        rdc(`CGR_REG_CFG, v);
        por();
        rdc(`CGR_REG_CFG, v);
        u_host.op(`CGR_INS_LOCKPROG, 32'h00000000);
        rdc(`CGR_REG_CFG, 32'h00000000);
        por();
        rdc(`CGR_REG_STAT, 32'h00000006);
        u_host.op(`CGR_INS_ERASE, 32'h00000000);
        rdc(`CGR_REG_STAT, 32'h00000002);
        por();
        v = $random(seed);
        u_host.op(`CGR_INS_SIGWRITE, v);
        rdc(`CGR_REG_SIG, v);
        u_host.op(`CGR_INS_USERCODE, 32'h00000000);
        chk(tdo, v[0]);
        chk(tdo_oe, 1'b1);
        results();
    end
endmodule
